/* File: rtl/uft_bit_clk.sv */
// uft_bit_clk: baud down-counter, bit-rate divider and sync clock edge logic
`timescale 1ns/10ps
`default_nettype none
module uft_bit_clk
  import uft_pkg::*;
(
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // settings
  input  wire uft_pkg::uft_fmt_t fmt,
  input  wire logic [11:0]      baudDiv,
  input  wire logic             baudReload,
  input  wire logic             xckMaster,
  // sync clock pin input
  input  wire logic             xckIn,
  // enables and sync clock level
  output logic                  txTick,
  output logic                  rxTick,
  output logic [3:0]            rxOvs,
  output logic                  xckLvl
);
  logic [11:0] baudCnt_r;
  logic [3:0]  divCnt_r;
  logic [3:0]  ovs;
  logic        baudTick;
  logic        xckS1_r, xckS2_r, xckS3_r;
  logic        chgEdge, smpEdge;

  // ==========================================================================
  // baud generator: reloads on zero or on a low-byte write
  assign baudTick = (baudCnt_r == 12'h000);
  always_ff @(posedge clk_sys) begin
    if (rst || baudReload || baudTick) begin
      baudCnt_r <= rst ? BAUD_RST : baudDiv;
    end else begin
      baudCnt_r <= baudCnt_r - 12'h001;
    end
  end

  // divide by 16, 8 or 2 depending on mode
  assign ovs = fmt.syncMode ? OVS_SYNC : (fmt.dblSpeed ? OVS_DBL : OVS_NORM);
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      divCnt_r <= 4'h0;
      xckLvl   <= 1'b0;
    end else if (baudTick) begin
      divCnt_r <= (divCnt_r == 4'h0) ? ovs : divCnt_r - 4'h1;
      xckLvl   <= (divCnt_r == 4'h0) ^ fmt.clkPol;
    end
  end

  // ==========================================================================
  // external sync clock: three stages, then the edge detector compares stages two and three
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xckS1_r <= 1'b0;
      xckS2_r <= 1'b0;
      xckS3_r <= 1'b0;
    end else begin
      xckS1_r <= xckIn;
      xckS2_r <= xckS1_r;
      xckS3_r <= xckS2_r;
    end
  end
  // polarity picks which edge changes data; the other one samples
  assign chgEdge = fmt.clkPol ? (xckS3_r & ~xckS2_r) : (xckS2_r & ~xckS3_r);
  assign smpEdge = fmt.clkPol ? (xckS2_r & ~xckS3_r) : (xckS3_r & ~xckS2_r);

  // bit enables: internal divider or the sync clock pin
  always_comb begin
    txTick = baudTick & (divCnt_r == 4'h0);
    rxTick = baudTick;
    rxOvs  = ovs;
    if (fmt.syncMode) begin
      rxOvs = 4'h0;
      if (!xckMaster) begin
        txTick = chgEdge;
        rxTick = smpEdge;
      end else begin
        rxTick = baudTick & (divCnt_r != 4'h0);
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/uft_pkg.sv */
// uft_pkg: register map, field layout, types and helpers of the frame transmitter
`default_nettype none
package uft_pkg;
  // ==========================================================================
  // register map, byte addresses on the bus
  localparam logic [4:0] ADR_DATA = 5'h00;
  localparam logic [4:0] ADR_CSA  = 5'h04;
  localparam logic [4:0] ADR_CSB  = 5'h08;
  localparam logic [4:0] ADR_CSC  = 5'h0c;  // shared with baud_div_high
  localparam logic [4:0] ADR_BDL  = 5'h10;

  // ==========================================================================
  // field positions
  localparam int CSA_RXC   = 7;
  localparam int CSA_TXC   = 6;
  localparam int CSA_TX_BUFFER_EMPTY_FLAG  = 5;
  localparam int CSA_FE    = 4;
  localparam int CSA_U2X   = 1;
  localparam int CSB_RXEN  = 4;
  localparam int CSB_TX_ENABLE_BIT  = 3;
  localparam int CSB_CSZ2  = 2;
  localparam int CSB_RXB8  = 1;
  localparam int CSB_TX_NINTH_BIT  = 0;
  localparam int CSC_SEL   = 7;
  localparam int CSC_SYNC  = 6;
  localparam int CSC_PARHI = 5;
  localparam int CSC_PARLO = 4;
  localparam int CSC_STOP  = 3;
  localparam int CSC_CSZHI = 2;
  localparam int CSC_CSZLO = 1;
  localparam int CSC_CPOL  = 0;

  // ==========================================================================
  // encodings and divider counts (count = divide ratio minus one)
  localparam logic [2:0] CSZ_NINE = 3'h7;
  localparam logic [3:0] OVS_NORM = 4'hf;
  localparam logic [3:0] OVS_DBL  = 4'h7;
  localparam logic [3:0] OVS_SYNC = 4'h1;

  // ==========================================================================
  // types
  typedef struct packed {
    logic [2:0] charSize;
    logic [1:0] parMode;
    logic       twoStop;
    logic       syncMode;
    logic       clkPol;
    logic       dblSpeed;
  } uft_fmt_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000, TX_START = 3'b001, TX_DATA = 3'b011,
    TX_PAR = 3'b010, TX_STOP1 = 3'b110, TX_STOP2 = 3'b111
  } uft_tx_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000, RX_START = 3'b001, RX_DATA = 3'b011,
    RX_PAR = 3'b010, RX_STOP = 3'b110
  } uft_rx_t;

  // ==========================================================================
  // reset values: 8 data bits, no parity, one stop, asynchronous
  localparam uft_fmt_t   FMT_RST  = 9'b011_00_0_0_0_0;
  localparam logic [11:0] BAUD_RST = 12'h000;

  // ==========================================================================
  // helpers
  function automatic logic [3:0] dataBits(input logic [2:0] code);
    unique case (code)
      3'h0: dataBits = 4'h5;
      3'h1: dataBits = 4'h6;
      3'h2: dataBits = 4'h7;
      3'h7: dataBits = 4'h9;
      default: dataBits = 4'h8;  // reserved codes behave as eight bits
    endcase
  endfunction

  function automatic logic [8:0] dataMask(input logic [2:0] code);
    dataMask = 9'h1ff >> (4'h9 - dataBits(code));
  endfunction

  function automatic logic parityBit(input logic [8:0] d, input logic [2:0] code,
                                     input logic odd);
    parityBit = (^(d & dataMask(code))) ^ odd;
  endfunction
endpackage
`default_nettype wire

/* File: rtl/uft_top.sv */
// uft_top: serial frame transmitter and receiver with a Wishbone register file
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module uft_top
  import uft_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [4:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // cpu side
  input  wire logic        txcIntAck,
  // serial pins
  input  wire logic        rxdIn,
  output logic             txdOut,
  output logic             txdOeN,
  input  wire logic        xckIn,
  output logic             xckOut,
  output logic             xckOeN,
  // general-purpose port values when the pins are not taken
  input  wire logic        gpioTxOut,
  input  wire logic        gpioTxOeN,
  input  wire logic        gpioXckOut,
  input  wire logic        gpioXckOeN,
  input  wire logic        xckDirOut
);
  uft_fmt_t    fmt_r;
  logic [11:0] baudDiv_r;
  logic        tx_enable_bit_r, rxEn_r, txNinth_r;
  logic [8:0]  bufData_r;
  logic        bufFull_r, txc_r;
  uft_tx_t     txState_r;
  logic [8:0]  shift_r;
  logic [3:0]  bitCnt_r;
  logic        txPar_r, line_r;
  uft_rx_t     rxState_r;
  logic [3:0]  rxCnt_r, rxBits_r;
  logic [8:0]  rxShift_r, rxBuf_r;
  logic        rxc_r, fe_r, rxS1_r, rxS2_r;
  logic        wbAck_r;
  logic [7:0]  wbDat_r, rdMux;
  logic        wbReq, acc, wr, rd;
  logic        wrData, wrCsa, wrCsb, wrCsc, wrBdl;
  logic        txTick, rxTick, xckLvl;
  logic [3:0]  rxOvs;
  logic        txActive, lastStop, loadNow, endFrame, ownTx, ownXck;
  logic        rxSample;

  // ==========================================================================
  // bus slave: ack one cycle after the request, effects on the ack edge
  assign wbReq = wb_cyc_i & wb_stb_i;
  assign acc = wbReq & wbAck_r;
  assign wr = acc & wb_we_i & wb_sel_i[0];
  assign rd = acc & ~wb_we_i;
  assign wrData = wr & (wb_adr_i == ADR_DATA);
  assign wrCsa = wr & (wb_adr_i == ADR_CSA);
  assign wrCsb = wr & (wb_adr_i == ADR_CSB);
  assign wrCsc = wr & (wb_adr_i == ADR_CSC);
  assign wrBdl = wr & (wb_adr_i == ADR_BDL);
  assign wb_ack_o = wbAck_r;
  assign wb_dat_o = {24'h000000, wbDat_r};

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wbAck_r <= 1'b0;
    end else begin
      wbAck_r <= wbReq & ~wbAck_r;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rdMux = 8'h00;
    unique case (wb_adr_i)
      ADR_DATA: rdMux = rxBuf_r[7:0];
      ADR_CSA: begin
        rdMux[CSA_RXC]  = rxc_r;
        rdMux[CSA_TXC]  = txc_r;
        rdMux[CSA_TX_BUFFER_EMPTY_FLAG] = ~bufFull_r;
        rdMux[CSA_FE]   = fe_r;
        rdMux[CSA_U2X]  = fmt_r.dblSpeed;
      end
      ADR_CSB: begin
        rdMux[CSB_RXEN] = rxEn_r;
        rdMux[CSB_TX_ENABLE_BIT] = tx_enable_bit_r;
        rdMux[CSB_CSZ2] = fmt_r.charSize[2];
        rdMux[CSB_RXB8] = rxBuf_r[8];
        rdMux[CSB_TX_NINTH_BIT] = txNinth_r;
      end
      ADR_CSC: rdMux = {1'b1, fmt_r.syncMode, fmt_r.parMode, fmt_r.twoStop,
                        fmt_r.charSize[1:0], fmt_r.clkPol};
      ADR_BDL: rdMux = baudDiv_r[7:0];
      default: rdMux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wbDat_r <= 8'h00;
    end else if (wbReq && !wbAck_r) begin
      wbDat_r <= rdMux;
    end
  end

  // ==========================================================================
  // control registers; one format copy feeds both directions
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      fmt_r     <= FMT_RST;
      baudDiv_r <= BAUD_RST;
      tx_enable_bit_r    <= 1'b0;
      rxEn_r    <= 1'b0;
      txNinth_r <= 1'b0;
    end else begin
      if (wrCsa) begin
        fmt_r.dblSpeed <= wb_dat_i[CSA_U2X];
      end
      if (wrCsb) begin
        rxEn_r <= wb_dat_i[CSB_RXEN];
        tx_enable_bit_r <= wb_dat_i[CSB_TX_ENABLE_BIT];
        fmt_r.charSize[2] <= wb_dat_i[CSB_CSZ2];
        txNinth_r <= wb_dat_i[CSB_TX_NINTH_BIT];
      end
      // shared address: bit 7 steers the write to control C
      if (wrCsc && wb_dat_i[CSC_SEL]) begin
        fmt_r.syncMode <= wb_dat_i[CSC_SYNC];
        fmt_r.parMode  <= wb_dat_i[CSC_PARHI:CSC_PARLO];
        fmt_r.twoStop  <= wb_dat_i[CSC_STOP];
        fmt_r.charSize[1:0] <= wb_dat_i[CSC_CSZHI:CSC_CSZLO];
        fmt_r.clkPol   <= wb_dat_i[CSC_CPOL];
      end else if (wrCsc) begin
        baudDiv_r[11:8] <= wb_dat_i[3:0];
      end
      if (wrBdl) begin
        baudDiv_r[7:0] <= wb_dat_i[7:0];
      end
    end
  end

  // ==========================================================================
  // bit clock enables
  uft_bit_clk u_bit_clk (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .fmt        (fmt_r),
    .baudDiv    (baudDiv_r),
    .baudReload (wrBdl),
    .xckMaster  (xckDirOut),
    .xckIn      (xckIn),
    .txTick     (txTick),
    .rxTick     (rxTick),
    .rxOvs      (rxOvs),
    .xckLvl     (xckLvl)
  );

  // ==========================================================================
  // transmit buffer; a new write wins over the move into the shifter
  assign txActive = (txState_r != TX_IDLE);
  assign lastStop = (txState_r == TX_STOP2) || (txState_r == TX_STOP1 && !fmt_r.twoStop);
  assign endFrame = txTick & lastStop;
  assign loadNow = txTick & bufFull_r & (tx_enable_bit_r | txActive) &
                   ((txState_r == TX_IDLE) | lastStop);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      bufData_r <= 9'h000;
      bufFull_r <= 1'b0;
    end else if (wrData) begin
      bufData_r <= {txNinth_r, wb_dat_i[7:0]};
      bufFull_r <= 1'b1;
    end else if (loadNow) begin
      bufFull_r <= 1'b0;
    end
  end

  // completion flag: a finishing frame beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txc_r <= 1'b0;
    end else if (endFrame && !bufFull_r) begin
      txc_r <= 1'b1;
    end else if (txcIntAck || (wrCsa && wb_dat_i[CSA_TXC])) begin
      txc_r <= 1'b0;
    end
  end

  // ==========================================================================
  // frame sequencer; line_r is the serial bit being sent
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txState_r <= TX_IDLE;
      shift_r   <= 9'h000;
      bitCnt_r  <= 4'h0;
      txPar_r   <= 1'b0;
      line_r    <= 1'b1;
    end else if (loadNow) begin
      txState_r <= TX_START;
      shift_r   <= bufData_r & dataMask(fmt_r.charSize);
      bitCnt_r  <= dataBits(fmt_r.charSize) - 4'h1;
      txPar_r   <= parityBit(bufData_r, fmt_r.charSize, fmt_r.parMode[0]);
      line_r    <= 1'b0;
    end else if (txTick) begin
      unique case (txState_r)
        TX_IDLE: line_r <= 1'b1;
        TX_START: begin
          line_r    <= shift_r[0];
          shift_r   <= shift_r >> 1;
          txState_r <= TX_DATA;
        end
        TX_DATA: begin
          if (bitCnt_r != 4'h0) begin
            line_r   <= shift_r[0];
            shift_r  <= shift_r >> 1;
            bitCnt_r <= bitCnt_r - 4'h1;
          end else if (fmt_r.parMode[1]) begin
            line_r    <= txPar_r;
            txState_r <= TX_PAR;
          end else begin
            line_r    <= 1'b1;
            txState_r <= TX_STOP1;
          end
        end
        TX_PAR: begin
          line_r    <= 1'b1;
          txState_r <= TX_STOP1;
        end
        TX_STOP1: begin
          line_r    <= 1'b1;
          txState_r <= fmt_r.twoStop ? TX_STOP2 : TX_IDLE;
        end
        TX_STOP2: begin
          line_r    <= 1'b1;
          txState_r <= TX_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // pin ownership: disabling keeps the transmit pin until shifter and buffer are drained; the clock pin is released once both enables are clear
  assign ownTx = tx_enable_bit_r | txActive | bufFull_r;
  assign ownXck = fmt_r.syncMode & (tx_enable_bit_r | rxEn_r) & xckDirOut;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      txdOut <= 1'b1;
      txdOeN <= 1'b1;
      xckOut <= 1'b0;
      xckOeN <= 1'b1;
    end else begin
      txdOut <= ownTx ? line_r : gpioTxOut;
      txdOeN <= ownTx ? 1'b0 : gpioTxOeN;
      xckOut <= ownXck ? xckLvl : gpioXckOut;
      xckOeN <= (fmt_r.syncMode & (tx_enable_bit_r | rxEn_r)) ? ~xckDirOut : gpioXckOeN;
    end
  end

  // ==========================================================================
  // receiver: line synchronised, sampled mid-bit on the shared format
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxS1_r <= 1'b1;
      rxS2_r <= 1'b1;
    end else begin
      rxS1_r <= rxdIn;
      rxS2_r <= rxS1_r;
    end
  end

  assign rxSample = rxTick & rxEn_r & (rxState_r != RX_IDLE) & (rxCnt_r == 4'h0);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxState_r <= RX_IDLE;
      rxCnt_r   <= 4'h0;
      rxBits_r  <= 4'h0;
      rxShift_r <= 9'h000;
    end else if (!rxEn_r) begin
      rxState_r <= RX_IDLE;
    end else if (rxTick && rxState_r == RX_IDLE) begin
      if (!rxS2_r) begin
        // sync mode has no oversampling: the start edge is the start bit
        rxState_r <= (rxOvs == 4'h0) ? RX_DATA : RX_START;
        rxCnt_r   <= rxOvs >> 1;
        rxBits_r  <= dataBits(fmt_r.charSize) - 4'h1;
      end
    end else if (rxTick && !rxSample) begin
      rxCnt_r <= rxCnt_r - 4'h1;
    end else if (rxSample) begin
      rxCnt_r <= rxOvs;
      unique case (rxState_r)
        RX_START: rxState_r <= rxS2_r ? RX_IDLE : RX_DATA;
        RX_DATA: begin
          rxShift_r <= {rxS2_r, rxShift_r[8:1]};
          rxBits_r  <= rxBits_r - 4'h1;
          if (rxBits_r == 4'h0) begin
            rxState_r <= fmt_r.parMode[1] ? RX_PAR : RX_STOP;
          end
        end
        RX_PAR: rxState_r <= RX_STOP;
        RX_STOP: rxState_r <= RX_IDLE;
        default: rxState_r <= RX_IDLE;
      endcase
    end
  end

  // receive buffer and flags; a new character beats a read clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rxBuf_r <= 9'h000;
      rxc_r   <= 1'b0;
      fe_r    <= 1'b0;
    end else if (rxSample && rxState_r == RX_STOP) begin
      rxBuf_r <= rxShift_r >> (4'h9 - dataBits(fmt_r.charSize));
      rxc_r   <= 1'b1;
      fe_r    <= ~rxS2_r;
    end else if (rd && wb_adr_i == ADR_DATA) begin
      rxc_r <= 1'b0;
    end
  end

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  startLow_a: assert property (
    $rose(txState_r == TX_START) |-> !line_r && $past(bufFull_r))
    else $error("start bit not low or loaded from empty buffer");
  stopHigh_a: assert property (
    (txState_r == TX_STOP1 || txState_r == TX_STOP2) |-> line_r)
    else $error("stop bit not high");
  idleHigh_a: assert property (
    (txState_r == TX_IDLE && tx_enable_bit_r) |=> txdOut)
    else $error("idle line not high");
  parityPlace_a: assert property (
    $rose(txState_r == TX_PAR) |-> $past(txState_r) == TX_DATA && fmt_r.parMode[1])
    else $error("parity bit out of place");
  parityValue_a: assert property (
    $rose(txState_r == TX_PAR) |-> line_r == txPar_r)
    else $error("wrong parity bit");
  bufWrite_a: assert property (
    wrData |=> bufFull_r)
    else $error("buffer write did not clear empty flag");
  txDone_a: assert property (
    (endFrame && !bufFull_r) |=> txc_r && txState_r == TX_IDLE)
    else $error("completion flag not set");
  twoStop_a: assert property (
    (txTick && txState_r == TX_STOP1 && fmt_r.twoStop && !loadNow) |=> txState_r == TX_STOP2)
    else $error("second stop bit skipped");
  backToBack_a: assert property (
    (endFrame && bufFull_r && tx_enable_bit_r && !wrData) |=> txState_r == TX_START && !bufFull_r)
    else $error("pending data not loaded at frame end");
  frameErr_a: assert property (
    (rxSample && rxState_r == RX_STOP) |=> fe_r == !$past(rxS2_r) && rxc_r)
    else $error("framing error not from first stop");
  pinOwn_a: assert property (
    tx_enable_bit_r |=> !txdOeN)
    else $error("transmit pin not taken over");

  backToBackC_c: cover property (endFrame && bufFull_r);
  nineBit_c: cover property (loadNow && fmt_r.charSize == CSZ_NINE);
  frameErr_c: cover property (rxSample && rxState_r == RX_STOP && !rxS2_r);
endmodule
`default_nettype wire

/* File: tb/uft_line_peer.sv */
// uft_line_peer: remote serial receiver sampling the transmit line mid-bit
`timescale 1ns/10ps
`default_nettype none
module uft_line_peer (
  // clock and line
  input  wire logic       clk_sys,
  input  wire logic       txLine,
  input  wire logic [3:0] nBits,
  // own line and capture
  output logic            rxLine,
  output logic [11:0]     frame,
  output int              frames,
  output int              startCyc
);
  int cyc = 0;
  logic [11:0] f;
  // ==========================================================================
  // cycle count, read only just after an edge so it is race free
  always @(posedge clk_sys) cyc <= cyc + 1;
  // far end echoes what it hears, so its line idles high like ours
  assign rxLine = txLine;
  // bit 11 holds the start level, bits after start from bit 0 up
  initial begin
    frames = 0;
    frame = 12'h000;
    startCyc = 0;
    forever begin
      @(negedge txLine);
      repeat (8) @(posedge clk_sys);
      startCyc = cyc;
      f = {txLine, 11'h000};
      for (int k = 0; k < nBits; k++) begin
        repeat (16) @(posedge clk_sys);
        f[k] = txLine;
      end
      frame = f;
      frames = frames + 1;
    end
  end
endmodule
`default_nettype wire

/* File: tb/uft_top_test.sv */
// uft_top_test: self-checking bench of the frame transmitter
`timescale 1ns/10ps
`default_nettype none
module uft_top_test;
  import uft_pkg::*;
  typedef struct packed {
    logic [7:0]  ctlB;
    logic [7:0]  ctlC;
    logic [7:0]  data;
    logic [3:0]  nBits;
    logic [11:0] frame;
    logic [7:0]  rxData;
  } uft_row_t;
  // ==========================================================================
  // format rows: control B, control C, data, bits after start, line bits, echoed byte
  localparam uft_row_t ROWS [6] = '{
    '{8'h18, 8'h86, 8'h55, 4'h9, 12'h155, 8'h55},
    '{8'h18, 8'ha8, 8'hf3, 4'h8, 12'h0f3, 8'h13},
    '{8'h18, 8'hb4, 8'h80, 4'h9, 12'h180, 8'h00},
    '{8'h18, 8'hb6, 8'h01, 4'ha, 12'h201, 8'h01},
    '{8'h18, 8'h92, 8'hff, 4'h7, 12'h07f, 8'h3f},
    '{8'h1d, 8'h8e, 8'h0a, 4'hb, 12'h70a, 8'h0a}};
  logic        clk_sys = 1'b0;
  logic        rst = 1'b1;
  logic        wbCyc = 1'b0;
  logic        wbStb = 1'b0;
  logic        wbWe = 1'b0;
  logic [4:0]  wbAdr = 5'h00;
  logic [31:0] wbDat = 32'h0;
  logic [31:0] wbRd;
  logic        wbAck, txcAck = 1'b0, txdOut, txdOeN, rxd, txLine;
  logic        gpioOut = 1'b0, gpioOeN = 1'b1, xckOut, xckOeN;
  logic [3:0]  nBits = 4'h9;
  logic [11:0] frame;
  logic [11:0] q;
  int          frames, startCyc, t0, t1, failures = 0, checksDone = 0;
  always #4 clk_sys = ~clk_sys;
  // released transmit line floats to its pull-up
  assign txLine = txdOeN ? 1'b1 : txdOut;
  uft_top u_dut (.clk_sys(clk_sys), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'h1), .wb_dat_i(wbDat), .wb_dat_o(wbRd),
    .wb_ack_o(wbAck), .txcIntAck(txcAck), .rxdIn(rxd), .txdOut(txdOut), .txdOeN(txdOeN),
    .xckIn(1'b0), .xckOut(xckOut), .xckOeN(xckOeN), .gpioTxOut(gpioOut), .gpioTxOeN(gpioOeN),
    .gpioXckOut(1'b0), .gpioXckOeN(1'b1), .xckDirOut(1'b0));
  uft_line_peer u_peer (.clk_sys(clk_sys), .txLine(txLine), .nBits(nBits), .rxLine(rxd),
    .frame(frame), .frames(frames), .startCyc(startCyc));
  // ==========================================================================
  // compare, verdict and bus tasks
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checksDone++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checksDone, failures);
    if (failures == 0 && checksDone > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // classic cycle held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDat <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    q = {4'h0, wbRd[7:0]};
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    if (wbAck !== 1'b1) begin
      failures++;
      conclude();
    end
  endtask
  task automatic waitFrame(input int n0);
    int n;
    n = 0;
    while (frames == n0 && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    if (frames == n0) begin
      failures++;
      conclude();
    end
  endtask
  // ==========================================================================
  // reset state, format rows, then back-to-back frames and flag clearing
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    wb(1'b0, ADR_CSA, 8'h00);
    chk(q, 12'h020);
    wb(1'b1, ADR_CSC, 8'h00);
    wb(1'b0, ADR_CSC, 8'h00);
    chk(q, 12'h086);
    wb(1'b0, 5'h14, 8'h00);
    chk(q, 12'h000);
    chk({10'h000, txdOeN, txdOut}, 12'h002);
    // unowned pin follows the port values; level first so the line never dips
    gpioOut <= 1'b1;
    @(posedge clk_sys);
    gpioOeN <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk({10'h000, txdOeN, txdOut}, 12'h001);
    gpioOeN <= 1'b1;
    foreach (ROWS[i]) begin
      nBits <= ROWS[i].nBits;
      wb(1'b1, ADR_CSB, ROWS[i].ctlB);
      wb(1'b1, ADR_CSC, ROWS[i].ctlC);
      wb(1'b1, ADR_CSA, 8'h40);
      t0 = frames;
      wb(1'b1, ADR_DATA, ROWS[i].data);
      waitFrame(t0);
      chk(frame, ROWS[i].frame);
      repeat (16) @(posedge clk_sys);
      wb(1'b0, ADR_DATA, 8'h00);
      chk(q, {4'h0, ROWS[i].rxData});
      wb(1'b0, ADR_CSA, 8'h00);
      chk(q, 12'h060);
      chk({11'h000, txLine}, 12'h001);
    end
    wb(1'b1, ADR_CSB, 8'h08);
    wb(1'b1, ADR_CSC, 8'h86);
    nBits <= 4'h9;
    wb(1'b1, ADR_CSA, 8'h40);
    t0 = frames;
    wb(1'b1, ADR_DATA, 8'h0f);
    repeat (20) @(posedge clk_sys);
    wb(1'b1, ADR_DATA, 8'hc3);
    wb(1'b0, ADR_CSA, 8'h00);
    chk(q, 12'h000);
    waitFrame(t0);
    chk(frame, 12'h10f);
    t0 = frames;
    t1 = startCyc;
    waitFrame(t0);
    chk(frame, 12'h1c3);
    chk(12'(startCyc - t1), 12'h0a0);
    repeat (16) @(posedge clk_sys);
    wb(1'b0, ADR_CSA, 8'h00);
    chk(q, 12'h060);
    txcAck <= 1'b1;
    @(posedge clk_sys);
    txcAck <= 1'b0;
    wb(1'b0, ADR_CSA, 8'h00);
    chk(q, 12'h020);
    chk({11'h000, txdOeN}, 12'h000);
    chk({10'h000, xckOeN, xckOut}, 12'h002);
    conclude();
  end
endmodule
`default_nettype wire
